// ==== srw_pkg.sv ====
package srw_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_TIME_MS = 200;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam longint WD_PERIOD_MS = 1120;
  localparam int WD_CYCLES = int'(WD_PERIOD_MS * (1000000 / CLK_PERIOD_NS));
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Float probe: drive low for 7/8 of the period, high for the last 1/8
  localparam int PROBE_NUM = 7;
  localparam int PROBE_DEN = 8;
  localparam int CNT_W = 32;
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRW_ASSERT = 2'b00,
    SRW_HOLD = 2'b01,
    SRW_RUN = 2'b10
  } srw_state_type;
endpackage

// ==== srw_wd_if.sv ====
`timescale 1ns/1ps
interface srw_wd_if;
  logic run;
  logic expire;
  modport top (output run, input expire);
  modport wd (input run, output expire);
endinterface

// ==== srw_watchdog.sv ====
`timescale 1ns/1ps
module srw_watchdog #(
  parameter int WD_CYCLES = srw_pkg::WD_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic strobe_in,
  input wire logic probe_active,
  srw_wd_if.wd ctl
);
  localparam int W = srw_pkg::CNT_W;
  logic [W-1:0] count;
  logic last;

  // Edge detection on the strobe pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last <= 1'b0;
    end else begin
      last <= strobe_in;
    end
  end

  // Timeout counter, runs only out of reset, disabled while probing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      ctl.expire <= 1'b0;
    end else if (!ctl.run || probe_active) begin
      count <= '0;
      ctl.expire <= 1'b0;
    end else if (strobe_in != last) begin
      count <= '0;
      ctl.expire <= 1'b0;
    end else if (count >= W'(WD_CYCLES - 1)) begin
      ctl.expire <= 1'b1;
    end else begin
      count <= count + W'(1);
      ctl.expire <= 1'b0;
    end
  end
endmodule

// ==== srw_supervisor.sv ====
`timescale 1ns/1ps
// Operation
// - Hold reset 200 ms after supply rises
// - Supply low asserts reset outputs
// - Manual override low asserts reset
// - Debounce override, pulse at least 1 us
// - Hold count starts at override release
// - No strobe edge in timeout asserts reset
// - Timeout runs only while reset released
// - Strobe edge restarts full timeout
// - Expiry: hold reset, then restart watchdog
// - Floating strobe pin disables watchdog
// - Float probe: low 7/8, high 1/8
// - Hold interval between 140 and 400 ms
// - Short override glitches cause no reset
module srw_supervisor #(
  parameter bit HAS_OVERRIDE = 1'b1,
  parameter int HOLD_CYCLES = srw_pkg::HOLD_CYCLES,
  parameter int WD_CYCLES = srw_pkg::WD_CYCLES,
  parameter int DEBOUNCE_CYCLES = srw_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_level,
  input wire logic manual_override_n,
  input wire logic watchdog_strobe_in,
  output logic watchdog_strobe_out,
  output logic watchdog_strobe_oe_n,
  output logic reset_out_n,
  output logic reset_out
);
  localparam int W = srw_pkg::CNT_W;
  localparam int PROBE_LOW = int'((longint'(WD_CYCLES) * srw_pkg::PROBE_NUM)
                                  / srw_pkg::PROBE_DEN);
  srw_pkg::srw_state_type state;
  logic [W-1:0] hold_count;
  logic [W-1:0] db_count;
  logic [W-1:0] probe_count;
  logic ovr_low;
  logic probe_active;
  logic driven_seen;
  logic req;
  logic next_reset_n;
  srw_wd_if wdc();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Counter has reached the last cycle of a span
  function automatic logic at_last(input logic [W-1:0] cnt, input int span);
    return cnt >= W'(span - 1);
  endfunction

  // Reset may be released: running, no cause, no expiry
  function automatic logic release_ok(input srw_pkg::srw_state_type st, input logic cause,
                                      input logic expired);
    return (st == srw_pkg::SRW_RUN) && !cause && !expired;
  endfunction

  // ---------------------------------------------------------------
  // Override debounce
  // ---------------------------------------------------------------
  // Counts how long the override has stayed low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      db_count <= '0;
    end else if (!HAS_OVERRIDE || manual_override_n) begin
      db_count <= '0;
    end else if (!at_last(db_count, DEBOUNCE_CYCLES)) begin
      db_count <= db_count + W'(1);
    end
  end

  // Low level takes effect only once it has lasted; short glitches are lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_low <= 1'b0;
    end else if (!HAS_OVERRIDE || manual_override_n) begin
      ovr_low <= 1'b0;
    end else if (at_last(db_count, DEBOUNCE_CYCLES)) begin
      ovr_low <= 1'b1;
    end
  end

  assign req = !supply_level || ovr_low;

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  // Assert while cause present, then hold the full interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= srw_pkg::SRW_ASSERT;
      hold_count <= '0;
    end else begin
      case (state)
        srw_pkg::SRW_ASSERT: begin
          hold_count <= '0;
          if (!req) begin
            state <= srw_pkg::SRW_HOLD;
          end
        end
        srw_pkg::SRW_HOLD: begin
          if (req) begin
            state <= srw_pkg::SRW_ASSERT;
            hold_count <= '0;
          end else if (at_last(hold_count, HOLD_CYCLES)) begin
            state <= srw_pkg::SRW_RUN;
          end else begin
            hold_count <= hold_count + W'(1);
          end
        end
        srw_pkg::SRW_RUN: begin
          hold_count <= '0;
          if (req) begin
            state <= srw_pkg::SRW_ASSERT;
          end else if (wdc.expire) begin
            state <= srw_pkg::SRW_HOLD;
          end
        end
        default: begin
          state <= srw_pkg::SRW_ASSERT;
        end
      endcase
    end
  end

  // Watchdog only times while the reset is released
  assign wdc.run = release_ok(state, req, 1'b0);

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Release decision shared by both outputs
  always_comb begin
    next_reset_n = release_ok(state, req, wdc.expire);
  end

  // Active-low output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= next_reset_n;
    end
  end

  // Active-high output, asserted during reset in the dual variant only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_out <= !HAS_OVERRIDE;
    end else begin
      reset_out <= !HAS_OVERRIDE && !next_reset_n;
    end
  end

  // ---------------------------------------------------------------
  // Float probe
  // ---------------------------------------------------------------
  // Cycles the pull; a pin that disagrees with the pull is driven
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_count <= '0;
      driven_seen <= 1'b0;
    end else begin
      if (at_last(probe_count, WD_CYCLES)) begin
        probe_count <= '0;
        driven_seen <= 1'b0;
      end else begin
        probe_count <= probe_count + W'(1);
        if (probe_count != '0 && probe_count != W'(PROBE_LOW)
            && watchdog_strobe_in != watchdog_strobe_out) begin
          driven_seen <= 1'b1;
        end
      end
    end
  end

  // Probe stays active until a driver is seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_active <= 1'b1;
    end else if (driven_seen) begin
      probe_active <= 1'b0;
    end else if (at_last(probe_count, WD_CYCLES)) begin
      probe_active <= 1'b1;
    end
  end

  // Pull level: low for most of the period, high for the tail
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_strobe_out <= 1'b0;
    end else begin
      watchdog_strobe_out <= probe_count >= W'(PROBE_LOW);
    end
  end

  // Pull let go once a driver is seen, applied again next period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_strobe_oe_n <= 1'b0;
    end else begin
      watchdog_strobe_oe_n <= driven_seen;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog timer
  // ---------------------------------------------------------------
  // Pulse edges from the pin; held off by probe_active when left open
  srw_watchdog #(
    .WD_CYCLES(WD_CYCLES)
  ) u_wd (
    .clk(clk),
    .arst_n(arst_n),
    .strobe_in(watchdog_strobe_in),
    .probe_active(probe_active),
    .ctl(wdc.wd)
  );
endmodule

// ==== srw_properties.sv ====
`timescale 1ns/1ps
module srw_properties #(
  parameter bit HAS_OVERRIDE = 1'b1,
  parameter int HOLD_CYCLES = 50,
  parameter int WD_CYCLES = 400
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_level,
  input wire logic manual_override_n,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_strobe_out,
  input wire logic watchdog_strobe_oe_n,
  input wire logic reset_out_n,
  input wire logic reset_out
);
  int wd;
  int run;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since a strobe edge or reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wd <= 0;
    else if (!reset_out_n || watchdog_strobe_in != $past(watchdog_strobe_in)) wd <= 0;
    else wd <= wd + 1;
  end
  // Length of the current probe level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) run <= 0;
    else if (watchdog_strobe_out != $past(watchdog_strobe_out)) run <= 0;
    else run <= run + 1;
  end
  property p_sup; !supply_level |-> ##[1:2] !reset_out_n; endproperty
  a_sup: assert property (p_sup) else $error("no reset on low supply");
  property p_hold; $rose(reset_out_n) |-> $past(supply_level, HOLD_CYCLES); endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_mr; (!manual_override_n && HAS_OVERRIDE) [*6] |-> ##[0:2] !reset_out_n;
  endproperty
  a_mr: assert property (p_mr) else $error("override gave no reset");
  property p_rel; HAS_OVERRIDE && $rose(manual_override_n) && !reset_out_n
    |=> !reset_out_n [*8]; endproperty
  a_rel: assert property (p_rel) else $error("release hold too short");
  property p_hi; reset_out == (!HAS_OVERRIDE && !reset_out_n); endproperty
  a_hi: assert property (p_hi) else $error("high output mismatch");
  property p_early; $fell(reset_out_n) && supply_level && manual_override_n
    |-> wd >= WD_CYCLES - 4; endproperty
  a_early: assert property (p_early) else $error("early watchdog reset");
  property p_phi; $fell(watchdog_strobe_out) && !watchdog_strobe_oe_n
    && $past(!watchdog_strobe_oe_n, WD_CYCLES / 8) |-> run >= WD_CYCLES / 8 - 3
    && run <= WD_CYCLES / 8 + 3; endproperty
  a_phi: assert property (p_phi) else $error("probe high phase length");
  property p_plo; $rose(watchdog_strobe_out) && !watchdog_strobe_oe_n
    && $past(reset_out_n, WD_CYCLES * 7 / 8) |-> run >= WD_CYCLES * 7 / 8 - 3
    && run <= WD_CYCLES * 7 / 8 + 3; endproperty
  a_plo: assert property (p_plo) else $error("probe low phase length");
endmodule
bind srw_supervisor srw_properties #(.HAS_OVERRIDE(HAS_OVERRIDE), .HOLD_CYCLES(HOLD_CYCLES),
  .WD_CYCLES(WD_CYCLES)) u_props (
  .clk(clk), .arst_n(arst_n), .supply_level(supply_level), .manual_override_n(manual_override_n),
  .watchdog_strobe_in(watchdog_strobe_in), .watchdog_strobe_out(watchdog_strobe_out),
  .watchdog_strobe_oe_n(watchdog_strobe_oe_n), .reset_out_n(reset_out_n), .reset_out(reset_out));

// ==== srw_host.sv ====
`timescale 1ns/1ps
module srw_host (
  input wire logic clk,
  input wire logic en,
  input wire logic kick,
  input wire logic oe_n,
  input wire logic pull,
  output logic pin
);
  logic lvl = 1'b0;
  logic tog = 1'b0;
  // Strobe idles low, pulses high on request
  always @(posedge clk) begin
    lvl <= kick;
    tog <= ~tog;
  end
  // Host wins over weak pull; open pin wanders
  assign pin = en ? lvl : (!oe_n ? pull : tog);
endmodule

// ==== supervisory_reset_watchdog_tb_top.sv ====
`timescale 1ns/1ps
module supervisory_reset_watchdog_tb_top;
  localparam int HC = 50;
  localparam int WC = 400;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sup = 1'b0;
  logic mr_n = 1'b1;
  logic en = 1'b1;
  logic kick = 1'b0;
  logic pin, s_out, oe_n, rst_n;
  logic rst2_n, rst2;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  initial forever #5 clk = ~clk;
  srw_supervisor #(.HOLD_CYCLES(HC), .WD_CYCLES(WC), .DEBOUNCE_CYCLES(4)) DUT (
    .clk(clk), .arst_n(arst_n), .supply_level(sup), .manual_override_n(mr_n),
    .watchdog_strobe_in(pin), .watchdog_strobe_out(s_out), .watchdog_strobe_oe_n(oe_n),
    .reset_out_n(rst_n), .reset_out());
  // Dual-output variant, override ignored
  srw_supervisor #(.HAS_OVERRIDE(1'b0), .HOLD_CYCLES(HC), .WD_CYCLES(WC),
    .DEBOUNCE_CYCLES(4)) DUT_dual (
    .clk(clk), .arst_n(arst_n), .supply_level(sup), .manual_override_n(mr_n),
    .watchdog_strobe_in(pin), .watchdog_strobe_out(), .watchdog_strobe_oe_n(),
    .reset_out_n(rst2_n), .reset_out(rst2));
  srw_host host (.clk(clk), .en(en), .kick(kick), .oe_n(oe_n), .pull(s_out), .pin(pin));
  // Helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic chk_n(input string s, input int lo, input int hi);
    checks_done++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("wrong value %s exp %0d..%0d got %0d", s, lo, hi, n);
    end
  endtask
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (rst_n !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Scenarios
  task automatic t_kick;
    repeat (4) begin
      cyc(300);
      kick <= 1'b1;
      cyc(1);
      kick <= 1'b0;
      @(negedge clk);
      chk("kept alive", 1'b1, rst_n);
    end
  endtask
  task automatic t_timeout;
    wait_rst(0, WC + 20);
    chk_n("timeout", WC - 4, WC + 4);
    wait_rst(1, HC + 20);
    chk_n("expiry hold", HC - 1, HC + 4);
    wait_rst(0, WC + 20);
    chk_n("restart", WC - 4, WC + 4);
    wait_rst(1, HC + 20);
    chk_n("restart hold", HC - 1, HC + 4);
  endtask
  task automatic t_supply;
    @(posedge clk);
    sup <= 1'b0;
    wait_rst(0, 5);
    chk_n("supply low", 0, 3);
    cyc(99);
    @(negedge clk);
    chk("held", 1'b0, rst_n);
    chk("active high reset", 1'b1, rst2);
    @(posedge clk);
    sup <= 1'b1;
    wait_rst(1, HC + 20);
    chk_n("supply hold", HC, HC + 4);
  endtask
  task automatic t_manual;
    mr_n <= 1'b0;
    cyc(2);
    mr_n <= 1'b1;
    cyc(20);
    mr_n <= 1'b0;
    @(negedge clk);
    chk("glitch", 1'b1, rst_n);
    cyc(30);
    mr_n <= 1'b1;
    @(negedge clk);
    chk("override", 1'b0, rst_n);
    chk("dual ignores override", 1'b1, rst2_n);
    chk("dual high idle", 1'b0, rst2);
    wait_rst(1, HC + 20);
    chk_n("release hold", HC - 1, HC + 4);
  endtask
  task automatic t_float;
    @(posedge clk);
    en <= 1'b0;
    wait_rst(0, 4 * WC);
    chk_n("float", 4 * WC, 4 * WC);
    chk("probe pull", 1'b0, oe_n);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  // Main sequence
  initial begin
    cyc(20);
    arst_n <= 1'b1;
    cyc(1);
    sup <= 1'b1;
    wait_rst(1, HC + 20);
    chk_n("power hold", HC, HC + 4);
    t_kick;
    t_timeout;
    t_supply;
    cyc(1);
    t_manual;
    t_float;
    finish_test;
  end
endmodule
